// ===== rtl/fcwl_consts.vh
// Purpose: Constants for the flash configuration word loader.
// Assumes: Word addresses are program memory word addresses, 24-bit words.
// Notes:   Field positions, addresses and reset values of the decoded fields.
`ifndef FCWL_CONSTS_VH
`define FCWL_CONSTS_VH

// ----------------------------------------------------------------------
// Word addresses for the largest memory size
// ----------------------------------------------------------------------
`define FCWL_ADDR_W 24
`define FCWL_ADDR_WORD_ONE 24'h02abfe
`define FCWL_ADDR_WORD_TWO 24'h02abfc
`define FCWL_ADDR_WORD_THREE 24'h02abfa
`define FCWL_WORD_STEP 24'h000002

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define FCWL_WORD_W 24
`define FCWL_ERASED_WORD 24'h000000
`define FCWL_UNPROG_WORD 24'hffffff

// Word one fields.
`define FCWL_W1_SCAN 14
`define FCWL_W1_GCP 13
`define FCWL_W1_GENERAL_WRITE_PROTECT 12
`define FCWL_W1_DEBUG 11
`define FCWL_W1_ICS_HI 9
`define FCWL_W1_ICS_LO 8
`define FCWL_W1_WDTEN 7
`define FCWL_W1_WATCHDOG_WINDOW_DISABLE 6
`define FCWL_W1_PSA 4
`define FCWL_W1_PS_HI 3
`define FCWL_W1_PS_LO 0

// Word two fields.
`define FCWL_W2_TWO_SPEED_STARTUP_ENABLE 15
`define FCWL_W2_OSC_HI 10
`define FCWL_W2_OSC_LO 8
`define FCWL_W2_CKSM_HI 7
`define FCWL_W2_CKSM_LO 6
`define FCWL_W2_OSCIO 5
`define FCWL_W2_LOCK1 4
`define FCWL_W2_I2C 2
`define FCWL_W2_POSC_HI 1
`define FCWL_W2_POSC_LO 0

// Word three fields.
`define FCWL_W3_END 15
`define FCWL_W3_CFG 14
`define FCWL_W3_DIS 13
`define FCWL_W3_FP_HI 7
`define FCWL_W3_FP_LO 0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define FCWL_ICS_RESERVED 2'h0
`define FCWL_OSC_RESERVED 3'h6
`define FCWL_OSC_FRC 3'h0
`define FCWL_POSC_DISABLED 2'h3
`define FCWL_POSC_EC 2'h0
`define FCWL_PRESCALE_HI 8'h80
`define FCWL_PRESCALE_LO 8'h20
`define FCWL_PAGE_WORDS_LOG2 9

`endif

// ===== rtl/fcwl_loader.v
// Purpose: Copies three flash configuration words into volatile registers on
//          every reset and decodes their fields into configuration outputs.
// Assumes: Flash read port answers a request with read data valid some cycles
//          later; only one read is outstanding at a time.
// Notes:   Configuration outputs hold between loads and change only once a load completes.
`timescale 1ns/1ps
`default_nettype none
`include "fcwl_consts.vh"

// What this block does
// - Every reset copies the packed configuration words from flash into volatile registers.
// - The load repeats after every reset kind, not only at power-up.
// - Fetch three words at the top of memory; smaller memories use lower addresses.
// - Upper byte of each word carries nothing and is ignored.
// - Erased last page gives zero words, which turn code protection on.
// - Word one bit 14 enables the boundary-scan port.
// - Word one bit 13 low protects all program memory.
// - Word one bit 12 low blocks program memory writes.
// - Word one bit 11 picks operational mode (1) or debug mode (0).
// - Word one bits 9-8 pick emulator pin pair; 00 reserved.
// - Word one bit 7 enables the watchdog.
// - Word one bit 6 low selects windowed watchdog; software must enable watchdog.
// - Word one bit 4 selects watchdog prescale 1:128 or 1:32.
// - Word one bits 3-0 give watchdog postscale of two to that power.
// - Word two bit 15 enables two-speed start-up.
// - Word two bits 10-8 select initial oscillator; 110 reserved.
// - Word two bits 7-6 configure clock switching and fail-safe monitor.
// - Word two bit 5 picks clock-out or port pin when primary mode is 11/00.
// - Word two bit 4 makes the pin-select lock settable only once.
// - Word two bit 2 routes second I2C to primary or alternate pins.
// - Word two bits 1-0 set primary oscillator mode.
// - Word three bit 13 high disables segmented code protection.
// - Word three bits 7-0 name boundary page; bit 15 picks segment direction.
module fcwl_loader #(
    parameter [23:0] mem_top_offset = 24'h000000,
    parameter largest_package = 1'b1
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Flash read port
    output reg flash_rd_req,
    output reg [23:0] flash_rd_addr,
    input wire flash_rd_valid,
    input wire [23:0] flash_rd_data,
    // Load status
    output reg load_busy,
    output reg load_done,
    // Raw configuration words, upper byte read as ones
    output wire [23:0] config_word_one,
    output wire [23:0] config_word_two,
    output wire [23:0] config_word_three,
    // Word one decode
    output wire scan_port_enable,
    output wire general_code_protect,
    output wire general_write_protect,
    output wire reset_into_debug,
    output wire [1:0] emulator_pin_pair_select,
    output wire prog_pin_pair_one,
    output wire prog_pin_pair_two,
    output wire prog_pin_pair_three,
    output wire emulator_pair_invalid,
    output wire watchdog_enable_cfg,
    output wire watchdog_window_disable,
    output wire watchdog_window_conflict,
    output wire watchdog_prescale_select,
    output wire [7:0] watchdog_prescale_ratio,
    output wire [3:0] watchdog_postscale_select,
    output wire [15:0] watchdog_postscale_ratio,
    // Word two decode
    output wire two_speed_startup_enable,
    output wire [2:0] initial_osc_select,
    output wire initial_osc_invalid,
    output wire [1:0] clock_switch_monitor_cfg,
    output wire clock_switch_enable,
    output wire fail_safe_monitor_enable,
    output wire osc_out_pin_function,
    output wire osc_output_pin_clock_out,
    output wire pin_lock_one_way,
    output wire second_i2c_pin_select,
    output wire i2c_two_primary_pins,
    output wire i2c_two_alternate_pins,
    output wire [1:0] primary_osc_mode,
    // Word three decode
    output wire segment_end_select,
    output wire config_page_protect_select,
    output wire segment_protect_disable,
    output wire segment_protect_active,
    output wire [7:0] segment_boundary_page,
    output wire [23:0] segment_low_addr,
    output wire [23:0] segment_high_addr,
    // Pin-select lock control
    input wire unlock_done,
    input wire lock_set_req,
    input wire lock_clear_req,
    output wire pin_select_lock
);

    // ------------------------------------------------------------------
    // States and local constants
    // ------------------------------------------------------------------
    localparam [2:0] st_idle = 3'h0;
    localparam [2:0] st_req = 3'h1;
    localparam [2:0] st_wait = 3'h2;
    localparam [2:0] st_done = 3'h3;

    // Address of a word, counted down from the top of memory.
    function [23:0] word_addr;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: word_addr = `FCWL_ADDR_WORD_ONE - mem_top_offset;
                2'h1: word_addr = `FCWL_ADDR_WORD_TWO - mem_top_offset;
                default: word_addr = `FCWL_ADDR_WORD_THREE - mem_top_offset;
            endcase
        end
    endfunction

    // Upper byte forced to ones so it never carries configuration.
    function [23:0] strip_upper;
        input [23:0] w;
        begin
            strip_upper = {8'hff, w[15:0]};
        end
    endfunction

    // Sequencer state, the shadow words and the visible words. The visible
    // words take no reset, so the decodes stay steady while reset is held.
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] idx_q;
    reg [1:0] idx_d;
    reg [23:0] shadow_one_q;
    reg [23:0] shadow_two_q;
    reg [23:0] shadow_three_q;
    reg [23:0] word_one_q;
    reg [23:0] word_two_q;
    reg [23:0] word_three_q;
    reg lock_q;

    // ------------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------------
    // Next-state logic for the three-word fetch.
    // Only one read is outstanding, so a late answer is never taken as the next word.
    always @* begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            st_idle: begin
                state_d = st_req;
                idx_d = 2'h0;
            end
            st_req: begin
                state_d = st_wait;
            end
            st_wait: begin
                if (flash_rd_valid) begin
                    if (idx_q == 2'h2) begin
                        state_d = st_done;
                    end else begin
                        idx_d = idx_q + 2'h1;
                        state_d = st_req;
                    end
                end
            end
            st_done: begin
                state_d = st_done;
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!resetn) begin
            state_q <= st_idle;
            idx_q <= 2'h0;
            flash_rd_req <= 1'b0;
            flash_rd_addr <= 24'h000000;
            load_busy <= 1'b1;
            load_done <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            flash_rd_req <= (state_d == st_req);
            flash_rd_addr <= word_addr(idx_d);
            load_busy <= (state_d != st_done);
            load_done <= (state_d == st_done);
        end
    end

    // Raw words gather in a shadow while the load runs.
    always @(posedge clk) begin
        if (!resetn) begin
            shadow_one_q <= `FCWL_UNPROG_WORD;
            shadow_two_q <= `FCWL_UNPROG_WORD;
            shadow_three_q <= `FCWL_UNPROG_WORD;
        end else if (state_q == st_wait && flash_rd_valid) begin
            case (idx_q)
                2'h0: shadow_one_q <= strip_upper(flash_rd_data);
                2'h1: shadow_two_q <= strip_upper(flash_rd_data);
                default: shadow_three_q <= strip_upper(flash_rd_data);
            endcase
        end
    end

    // Visible words keep their contents through reset and change only
    // when the last word arrives, so no half-loaded set is ever seen.
    // update at load end
    always @(posedge clk) begin
        if (resetn && state_q == st_wait && flash_rd_valid && idx_q == 2'h2) begin
            word_one_q <= shadow_one_q;
            word_two_q <= shadow_two_q;
            word_three_q <= strip_upper(flash_rd_data);
        end
    end

    assign config_word_one = word_one_q;
    assign config_word_two = word_two_q;
    assign config_word_three = word_three_q;

    // ------------------------------------------------------------------
    // Word one decode
    // ------------------------------------------------------------------
    // An erased word reads all zeros and the protect bits are active low,
    // so a wiped last page falls back to full code and write protection.
    // erased words protect
    assign scan_port_enable = word_one_q[`FCWL_W1_SCAN];

    assign general_code_protect = ~word_one_q[`FCWL_W1_GCP];

    assign general_write_protect = ~word_one_q[`FCWL_W1_GENERAL_WRITE_PROTECT];

    assign reset_into_debug = ~word_one_q[`FCWL_W1_DEBUG];

    // The pair strobes are one-hot; the reserved code raises only the
    // invalid flag and leaves all three pairs unselected.
    // emulator pin pair
    assign emulator_pin_pair_select = word_one_q[`FCWL_W1_ICS_HI:`FCWL_W1_ICS_LO];
    assign prog_pin_pair_one = (emulator_pin_pair_select == 2'h3);
    assign prog_pin_pair_two = (emulator_pin_pair_select == 2'h2);
    assign prog_pin_pair_three = (emulator_pin_pair_select == 2'h1);
    assign emulator_pair_invalid = (emulator_pin_pair_select == `FCWL_ICS_RESERVED);

    assign watchdog_enable_cfg = word_one_q[`FCWL_W1_WDTEN];

    // Windowed mode with the watchdog off is a setting software must avoid;
    // the conflict flag lets the watchdog side see it.
    // windowed watchdog mode
    assign watchdog_window_disable = word_one_q[`FCWL_W1_WATCHDOG_WINDOW_DISABLE];
    assign watchdog_window_conflict = ~watchdog_window_disable & ~watchdog_enable_cfg;

    assign watchdog_prescale_select = word_one_q[`FCWL_W1_PSA];
    assign watchdog_prescale_ratio = watchdog_prescale_select ? `FCWL_PRESCALE_HI : `FCWL_PRESCALE_LO;

    assign watchdog_postscale_select = word_one_q[`FCWL_W1_PS_HI:`FCWL_W1_PS_LO];
    assign watchdog_postscale_ratio = 16'h0001 << watchdog_postscale_select;

    // ------------------------------------------------------------------
    // Word two decode
    // ------------------------------------------------------------------
    // two-speed start-up
    assign two_speed_startup_enable = word_two_q[`FCWL_W2_TWO_SPEED_STARTUP_ENABLE];

    assign initial_osc_select = word_two_q[`FCWL_W2_OSC_HI:`FCWL_W2_OSC_LO];
    assign initial_osc_invalid = (initial_osc_select == `FCWL_OSC_RESERVED);

    assign clock_switch_monitor_cfg = word_two_q[`FCWL_W2_CKSM_HI:`FCWL_W2_CKSM_LO];
    assign clock_switch_enable = ~clock_switch_monitor_cfg[1];
    assign fail_safe_monitor_enable = (clock_switch_monitor_cfg == 2'h0);

    assign primary_osc_mode = word_two_q[`FCWL_W2_POSC_HI:`FCWL_W2_POSC_LO];

    // The output pin is free for the clock only when the primary oscillator
    // is off or fed from an external clock; crystal modes keep the pin.
    // clock-out pin function
    assign osc_out_pin_function = word_two_q[`FCWL_W2_OSCIO];
    assign osc_output_pin_clock_out = osc_out_pin_function &
        (primary_osc_mode == `FCWL_POSC_DISABLED || primary_osc_mode == `FCWL_POSC_EC);

    assign pin_lock_one_way = word_two_q[`FCWL_W2_LOCK1];

    // Smaller packages lack the alternate pins, so the select reads as one.
    // second I2C pins
    assign second_i2c_pin_select = largest_package ? word_two_q[`FCWL_W2_I2C] : 1'b1;
    assign i2c_two_primary_pins = second_i2c_pin_select;
    assign i2c_two_alternate_pins = ~second_i2c_pin_select;

    // ------------------------------------------------------------------
    // Word three decode
    // ------------------------------------------------------------------
    // segment protection enable
    assign segment_end_select = word_three_q[`FCWL_W3_END];
    assign config_page_protect_select = word_three_q[`FCWL_W3_CFG];
    assign segment_protect_disable = word_three_q[`FCWL_W3_DIS];
    assign segment_protect_active = ~segment_protect_disable;

    // Pages are 512 words counted from the bottom; the boundary page itself
    // always lies inside the protected segment.
    // segment boundary page
    assign segment_boundary_page = word_three_q[`FCWL_W3_FP_HI:`FCWL_W3_FP_LO];
    assign segment_low_addr = segment_end_select ?
        ({16'h0000, segment_boundary_page} << `FCWL_PAGE_WORDS_LOG2) : 24'h000000;
    assign segment_high_addr = segment_end_select ? (`FCWL_ADDR_WORD_ONE - mem_top_offset) :
        ((({16'h0000, segment_boundary_page} + 24'h000001) << `FCWL_PAGE_WORDS_LOG2) - 24'h000001);

    // ------------------------------------------------------------------
    // Pin-select lock
    // ------------------------------------------------------------------
    // Set wins over a clear in the same cycle; a one-way lock ignores clears.
    // lock set once
    always @(posedge clk) begin
        if (!resetn) begin
            lock_q <= 1'b0;
        end else if (unlock_done && lock_set_req) begin
            lock_q <= 1'b1;
        end else if (unlock_done && lock_clear_req && !(pin_lock_one_way && lock_q)) begin
            lock_q <= 1'b0;
        end
    end

    assign pin_select_lock = lock_q;

endmodule // fcwl_loader
`default_nettype wire

// ===== verification/fcwl_props.sv
// Purpose: Concurrent checks on the configuration loader ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound into every loader instance; addresses follow the offset parameter.
`timescale 1ns/1ps
`default_nettype none
`include "fcwl_consts.vh"
module fcwl_props #(
    parameter [23:0] mem_top_offset = 24'h000000
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Flash read port
    input wire flash_rd_req,
    input wire [23:0] flash_rd_addr,
    input wire flash_rd_valid,
    // Status and decodes
    input wire load_busy,
    input wire load_done,
    input wire [23:0] config_word_one,
    input wire [23:0] config_word_two,
    input wire [23:0] config_word_three,
    input wire [7:0] watchdog_prescale_ratio,
    input wire [1:0] emulator_pin_pair_select,
    input wire prog_pin_pair_one,
    input wire pin_lock_one_way,
    input wire pin_select_lock
);
    localparam [23:0] A1 = `FCWL_ADDR_WORD_ONE - mem_top_offset;
    localparam [23:0] A3 = `FCWL_ADDR_WORD_THREE - mem_top_offset;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // The answer to the third read completes the copy.
    sequence s_last_word;
        load_busy && flash_rd_valid && flash_rd_addr == A3;
    endsequence
    // Read sequencing, completion, held words, upper byte, prescale and pair one decodes, and the one-way lock.
    first_read_a: assert property ($rose(resetn) |=> flash_rd_req && flash_rd_addr == A1)
        else $error("first read missing after reset");
    req_pulse_a: assert property (flash_rd_req |=> !flash_rd_req)
        else $error("read request longer than one cycle");
    addr_step_a: assert property (flash_rd_req && flash_rd_addr != A1 |-> flash_rd_addr == $past(flash_rd_addr) - 24'h000002)
        else $error("read address out of order");
    next_read_a: assert property (load_busy && flash_rd_valid && flash_rd_addr != A3 |=> flash_rd_req)
        else $error("next read not issued");
    load_finish_a: assert property (s_last_word |=> load_done && !load_busy)
        else $error("load not completed after third word");
    words_hold_a: assert property (load_done |=> $stable(config_word_one) && $stable(config_word_two) && $stable(config_word_three))
        else $error("configuration word changed between loads");
    upper_ones_a: assert property (load_done |-> (config_word_one[23:16] & config_word_two[23:16] & config_word_three[23:16]) == 8'hff)
        else $error("upper byte not ones");
    prescale_a: assert property (load_done |-> watchdog_prescale_ratio == (config_word_one[4] ? 8'h80 : 8'h20))
        else $error("prescale ratio wrong");
    pair_one_a: assert property (load_done |-> prog_pin_pair_one == (emulator_pin_pair_select == 2'b11))
        else $error("pin pair one decode wrong");
    lock_once_a: assert property (pin_select_lock && pin_lock_one_way |=> pin_select_lock)
        else $error("one-way lock cleared");
endmodule // fcwl_props
bind fcwl_loader fcwl_props #(.mem_top_offset(mem_top_offset)) u_fcwl_props (.clk, .resetn, .flash_rd_req,
    .flash_rd_addr, .flash_rd_valid, .load_busy, .load_done, .config_word_one, .config_word_two, .config_word_three,
    .watchdog_prescale_ratio, .emulator_pin_pair_select, .prog_pin_pair_one, .pin_lock_one_way, .pin_select_lock);
`default_nettype wire

// ===== verification/fcwl_flash_model.sv
// Purpose: Behavioural flash array answering configuration word reads.
// Assumes: One read outstanding; latency set by the bench in cycles.
// Notes:   Data lines toggle when no answer is presented.
`timescale 1ns/1ps
`default_nettype none
`include "fcwl_consts.vh"
module fcwl_flash_model #(
    parameter [23:0] mem_top_offset = 24'h000000
) (
    // Clock
    input wire clk,
    // Read port
    input wire flash_rd_req,
    input wire [23:0] flash_rd_addr,
    output reg flash_rd_valid,
    output reg [23:0] flash_rd_data
);
    reg [23:0] word_mem [0:2];
    reg [23:0] addr_log [0:2];
    reg [23:0] addr_q = 24'h000000;
    reg pend = 1'b0;
    integer n_rd = 0;
    integer lat = 1;
    integer cnt = 0;
    initial flash_rd_valid = 1'b0;
    initial flash_rd_data = 24'h000000;
    // words at the top, erased reads zero
    always @(posedge clk) begin
        flash_rd_valid <= 1'b0;
        flash_rd_data <= ~flash_rd_data;
        if (flash_rd_req) begin
            pend <= 1'b1;
            cnt <= lat;
            addr_q <= flash_rd_addr;
            addr_log[n_rd % 3] <= flash_rd_addr;
            n_rd <= n_rd + 1;
        end else if (pend && cnt <= 1) begin
            pend <= 1'b0;
            flash_rd_valid <= 1'b1;
            flash_rd_data <= word_mem[(`FCWL_ADDR_WORD_ONE - mem_top_offset - addr_q) >> 1];
        end else if (pend) begin
            cnt <= cnt - 1;
        end
    end
endmodule // fcwl_flash_model
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the configuration word loader.
// Assumes: Smaller memory size, offset 24'h020000.
// Notes:   Every load is started by a reset.
`timescale 1ns/1ps
`default_nettype none
`include "fcwl_consts.vh"
module tb;
    localparam [23:0] OFF = 24'h020000;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg unlock_done = 1'b0;
    reg lock_set_req = 1'b0;
    reg lock_clear_req = 1'b0;
    wire flash_rd_req, flash_rd_valid, load_busy, load_done;
    wire [23:0] flash_rd_addr, flash_rd_data, config_word_one, config_word_two, config_word_three;
    wire scan_port_enable, general_code_protect, general_write_protect, reset_into_debug, prog_pin_pair_two;
    wire emulator_pair_invalid, watchdog_window_conflict, two_speed_startup_enable, initial_osc_invalid;
    wire clock_switch_enable, fail_safe_monitor_enable, osc_output_pin_clock_out, i2c_two_alternate_pins;
    wire pin_lock_one_way, pin_select_lock, segment_protect_active;
    wire [7:0] watchdog_prescale_ratio;
    wire [15:0] watchdog_postscale_ratio;
    wire [23:0] segment_low_addr, segment_high_addr;
    integer error_cnt = 0;
    integer n_tests = 0;
    // Clock at 200 MHz.
    always #2.5 clk = ~clk;
    fcwl_flash_model #(.mem_top_offset(OFF)) u_fcwl_flash_model (.clk, .flash_rd_req, .flash_rd_addr,
        .flash_rd_valid, .flash_rd_data);
    fcwl_loader #(.mem_top_offset(OFF)) u_fcwl_loader (.clk, .resetn, .flash_rd_req, .flash_rd_addr,
        .flash_rd_valid, .flash_rd_data, .load_busy, .load_done, .config_word_one, .config_word_two,
        .config_word_three, .scan_port_enable, .general_code_protect, .general_write_protect, .reset_into_debug,
        .emulator_pin_pair_select(), .prog_pin_pair_one(), .prog_pin_pair_two, .prog_pin_pair_three(),
        .emulator_pair_invalid, .watchdog_enable_cfg(), .watchdog_window_disable(), .watchdog_window_conflict,
        .watchdog_prescale_select(), .watchdog_prescale_ratio, .watchdog_postscale_select(),
        .watchdog_postscale_ratio, .two_speed_startup_enable, .initial_osc_select(), .initial_osc_invalid,
        .clock_switch_monitor_cfg(), .clock_switch_enable, .fail_safe_monitor_enable, .osc_out_pin_function(),
        .osc_output_pin_clock_out, .pin_lock_one_way, .second_i2c_pin_select(), .i2c_two_primary_pins(),
        .i2c_two_alternate_pins, .primary_osc_mode(), .segment_end_select(), .config_page_protect_select(),
        .segment_protect_disable(), .segment_protect_active, .segment_boundary_page(), .segment_low_addr,
        .segment_high_addr, .unlock_done, .lock_set_req, .lock_clear_req, .pin_select_lock);
    // Counts one comparison and reports a mismatch.
    task chk(input [23:0] got, input [23:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Prints the verdict and ends the run.
    task close_out;
        begin
            if (error_cnt == 0 && n_tests > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Resets the block, lets it copy three words and checks the reads.
    task load(input [23:0] w1, input [23:0] w2, input [23:0] w3, input integer lat);
        integer i;
        reg [23:0] prev;
        begin
            prev = config_word_one;
            u_fcwl_flash_model.word_mem[0] = w1;
            u_fcwl_flash_model.word_mem[1] = w2;
            u_fcwl_flash_model.word_mem[2] = w3;
            u_fcwl_flash_model.lat = lat;
            @(posedge clk);
            resetn <= 1'b0;
            repeat (3) @(posedge clk);
            #1 u_fcwl_flash_model.n_rd = 0;
            chk(config_word_one, prev);
            @(posedge clk);
            resetn <= 1'b1;
            for (i = 0; i < 100 && load_done !== 1'b1; i = i + 1) begin
                @(posedge clk);
                #1;
            end
            if (load_done !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t load did not complete", $time);
                close_out;
            end
            chk(u_fcwl_flash_model.addr_log[0], `FCWL_ADDR_WORD_ONE - OFF);
            chk(u_fcwl_flash_model.addr_log[1], `FCWL_ADDR_WORD_TWO - OFF);
            chk(u_fcwl_flash_model.addr_log[2], `FCWL_ADDR_WORD_THREE - OFF);
            chk(config_word_one, {8'hff, w1[15:0]});
            chk(config_word_two, {8'hff, w2[15:0]});
            chk(config_word_three, {8'hff, w3[15:0]});
        end
    endtask
    // Tries the lock without unlock, then sets it and tries to clear it.
    task lock_seq(input exp_clr);
        begin
            @(posedge clk);
            lock_set_req <= 1'b1;
            @(posedge clk);
            lock_set_req <= 1'b0;
            #1 chk(pin_select_lock, 24'h0);
            @(posedge clk);
            unlock_done <= 1'b1;
            lock_set_req <= 1'b1;
            @(posedge clk);
            lock_set_req <= 1'b0;
            lock_clear_req <= 1'b1;
            #1 chk(pin_select_lock, 24'h1);
            @(posedge clk);
            lock_clear_req <= 1'b0;
            unlock_done <= 1'b0;
            #1 chk(pin_select_lock, exp_clr);
        end
    endtask
    // Field pattern with debug entry, pair two and one-way lock.
    task sc_pattern_a;
        begin
            load(24'h005695, 24'h008370, 24'h000003, 1);
            chk({scan_port_enable, general_code_protect, general_write_protect, reset_into_debug, prog_pin_pair_two,
                emulator_pair_invalid, watchdog_window_conflict}, 7'b1101100);
            chk(watchdog_prescale_ratio, 8'h80);
            chk(watchdog_postscale_ratio, 16'h0020);
            chk({two_speed_startup_enable, initial_osc_invalid, clock_switch_enable, fail_safe_monitor_enable,
                osc_output_pin_clock_out, i2c_two_alternate_pins, pin_lock_one_way, segment_protect_active},
                8'b10101111);
            chk(segment_low_addr, 24'h000000);
            chk(segment_high_addr, 24'h0007ff);
            lock_seq(1'b1);
        end
    endtask
    // Opposite field pattern, except clock switching stays enabled, behind a slow flash.
    task sc_pattern_b;
        begin
            load(24'h122c0f, 24'h000626, 24'hff2005, 4);
            chk({scan_port_enable, general_code_protect, general_write_protect, reset_into_debug, prog_pin_pair_two,
                emulator_pair_invalid, watchdog_window_conflict}, 7'b0010011);
            chk(watchdog_prescale_ratio, 8'h20);
            chk(watchdog_postscale_ratio, 16'h8000);
            chk({two_speed_startup_enable, initial_osc_invalid, clock_switch_enable, fail_safe_monitor_enable,
                osc_output_pin_clock_out, i2c_two_alternate_pins, pin_lock_one_way, segment_protect_active},
                8'b01110000);
            lock_seq(1'b0);
        end
    endtask
    // Walks every postscale, oscillator, clocking and primary mode code.
    task sc_codes;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                load({20'hff579, k[3:0]}, {13'h0000, k[2:0], k[1:0], 4'h8, k[3:2]}, 24'hffffff, k % 4 + 1);
                chk(watchdog_postscale_ratio, 24'h000001 << k);
                chk({initial_osc_invalid, clock_switch_enable, fail_safe_monitor_enable, osc_output_pin_clock_out},
                    {k[2:0] == 3'h6, ~k[1], k[1:0] == 2'h0, k[3:2] == 2'h3 || k[3:2] == 2'h0});
            end
            chk(segment_low_addr, 24'h01fe00);
            chk(segment_high_addr, `FCWL_ADDR_WORD_ONE - OFF);
        end
    endtask
    // Erased last page: all words read zero.
    task sc_erased;
        begin
            load(24'h000000, 24'h000000, 24'h000000, 2);
            chk({general_code_protect, general_write_protect, emulator_pair_invalid, segment_protect_active},
                4'b1111);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        sc_pattern_a;
        sc_pattern_b;
        sc_codes;
        sc_erased;
        close_out;
    end
endmodule // tb
`default_nettype wire
